// ===== src/albe_pkg.sv
// constants, operation codes and request layout for the execute block
package albe_pkg;

    // flag_register bit positions
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_S = 3'h4;
    localparam logic [2:0] FLAG_H = 3'h5;

    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] BYTE_ALL = 8'hff;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [15:0] WORD_ZERO = 16'h0000;

    // cycle counts
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;

    // program counter steps
    localparam int STEP_NEXT = 1;
    localparam int STEP_SKIP_ONE = 2;
    localparam int STEP_SKIP_TWO = 3;

    typedef enum logic [4:0] {
        OP_NOP = 5'h00,
        OP_ADD = 5'h01,
        OP_ADC = 5'h02,
        OP_SUB = 5'h03,
        OP_SBC = 5'h04,
        OP_CP = 5'h05,
        OP_CPC = 5'h06,
        OP_AND = 5'h07,
        OP_OR = 5'h08,
        OP_EOR = 5'h09,
        OP_SET_MASK = 5'h0a,
        OP_CLR_MASK = 5'h0b,
        OP_PROBE = 5'h0c,
        OP_WORD_SUM = 5'h0d,
        OP_WORD_MINUS = 5'h0e,
        OP_PTR_JUMP = 5'h0f,
        OP_PTR_CALL = 5'h10,
        OP_EQ_SKIP = 5'h11,
        OP_REG_BIT_SKIP = 5'h12,
        OP_PORT_BIT_SKIP = 5'h13,
        OP_FLAG_BRANCH = 5'h14,
        OP_SIGNED_BRANCH = 5'h15
    } albe_op_e;

    typedef struct packed {
        albe_op_e op;
        logic [7:0] dst;
        logic [7:0] src;
        logic [7:0] imm;
        logic use_imm;
        logic [15:0] pair;
        logic [15:0] z_ptr;
        logic [2:0] bit_sel;
        logic polarity;
        logic io_bit;
        logic signed [11:0] offset;
        logic skip_two_word;
    } albe_req_s;

endpackage

// ===== src/albe_core.sv
// execute unit for arithmetic, logic, compare, skip and branch operations
`timescale 1ns/100ps
module albe_core #(
    parameter int PC_W = 12
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic req_valid,
    input wire albe_pkg::albe_req_s req,
    output logic ready,
    output logic done,
    output logic wr8_en,
    output logic wr16_en,
    output logic [15:0] wr_data,
    output logic [7:0] flag_register,
    output logic [PC_W-1:0] program_counter,
    output logic push_en,
    output logic [PC_W-1:0] push_addr
);

    logic ready_q;
    logic done_q;
    logic [1:0] cnt_q;
    logic wr8_q;
    logic wr16_q;
    logic [15:0] wdata_q;
    logic [7:0] flags_q;
    logic [PC_W-1:0] pc_q;
    logic push_q;
    logic [PC_W-1:0] push_addr_q;

    logic accept;
    logic [7:0] flags_d;
    logic [PC_W-1:0] pc_d;
    logic [15:0] wdata_d;
    logic wr8_d;
    logic wr16_d;
    logic push_d;
    logic [1:0] cyc_d;

    // half carry, overflow, carry for byte add
    function automatic logic [2:0] add_hvc(input logic [7:0] a,
            input logic [7:0] b, input logic [7:0] r);
        add_hvc[2] = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
        add_hvc[1] = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
        add_hvc[0] = (a[7] & b[7]) | (b[7] & ~r[7]) | (~r[7] & a[7]);
    endfunction

    // half borrow, overflow, borrow for byte subtract
    function automatic logic [2:0] sub_hvc(input logic [7:0] a,
            input logic [7:0] b, input logic [7:0] r);
        sub_hvc[2] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
        sub_hvc[1] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
        sub_hvc[0] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
    endfunction

    assign accept = req_valid & ready_q;

    always_comb begin
        logic [7:0] opb;
        logic [7:0] r8;
        logic [15:0] r16;
        logic [2:0] hvc;
        logic cin;
        logic cond;
        logic [PC_W-1:0] pc_next;
        logic [PC_W-1:0] pc_rel;
        opb = req.use_imm ? req.imm : req.src;
        r8 = albe_pkg::BYTE_ZERO;
        r16 = albe_pkg::WORD_ZERO;
        hvc = 3'h0;
        cin = 1'b0;
        cond = 1'b0;
        pc_next = pc_q + PC_W'(albe_pkg::STEP_NEXT);
        pc_rel = pc_q + PC_W'(req.offset) + PC_W'(albe_pkg::STEP_NEXT);
        flags_d = flags_q;
        pc_d = pc_next;
        wdata_d = albe_pkg::WORD_ZERO;
        wr8_d = 1'b0;
        wr16_d = 1'b0;
        push_d = 1'b0;
        cyc_d = albe_pkg::CYC_ONE;
        case (req.op)
            albe_pkg::OP_ADD, albe_pkg::OP_ADC: begin
                cin = (req.op == albe_pkg::OP_ADC) &
                    flags_q[albe_pkg::FLAG_C];
                r8 = req.dst + opb + {7'h00, cin};
                hvc = add_hvc(req.dst, opb, r8);
                flags_d[albe_pkg::FLAG_H] = hvc[2];
                flags_d[albe_pkg::FLAG_V] = hvc[1];
                flags_d[albe_pkg::FLAG_C] = hvc[0];
                flags_d[albe_pkg::FLAG_N] = r8[7];
                flags_d[albe_pkg::FLAG_Z] = (r8 == albe_pkg::BYTE_ZERO);
                wr8_d = 1'b1;
                wdata_d = {albe_pkg::BYTE_ZERO, r8};
            end
            albe_pkg::OP_SUB, albe_pkg::OP_SBC,
            albe_pkg::OP_CP, albe_pkg::OP_CPC: begin
                cin = ((req.op == albe_pkg::OP_SBC) |
                    (req.op == albe_pkg::OP_CPC)) &
                    flags_q[albe_pkg::FLAG_C];
                r8 = req.dst - opb - {7'h00, cin};
                hvc = sub_hvc(req.dst, opb, r8);
                flags_d[albe_pkg::FLAG_H] = hvc[2];
                flags_d[albe_pkg::FLAG_V] = hvc[1];
                flags_d[albe_pkg::FLAG_C] = hvc[0];
                flags_d[albe_pkg::FLAG_N] = r8[7];
                // carry variants chain zero across bytes
                flags_d[albe_pkg::FLAG_Z] = (r8 == albe_pkg::BYTE_ZERO) &
                    (~cin_op(req.op) | flags_q[albe_pkg::FLAG_Z]);
                wr8_d = (req.op == albe_pkg::OP_SUB) |
                    (req.op == albe_pkg::OP_SBC);
                wdata_d = {albe_pkg::BYTE_ZERO, r8};
            end
            albe_pkg::OP_AND, albe_pkg::OP_OR, albe_pkg::OP_EOR,
            albe_pkg::OP_SET_MASK, albe_pkg::OP_CLR_MASK,
            albe_pkg::OP_PROBE: begin
                case (req.op)
                    albe_pkg::OP_AND: r8 = req.dst & opb;
                    albe_pkg::OP_OR: r8 = req.dst | opb;
                    albe_pkg::OP_EOR: r8 = req.dst ^ opb;
                    albe_pkg::OP_SET_MASK: r8 = req.dst | req.imm;
                    albe_pkg::OP_CLR_MASK:
                        r8 = req.dst &
                            (albe_pkg::BYTE_ALL - req.imm);
                    default: r8 = req.dst & req.dst;
                endcase
                flags_d[albe_pkg::FLAG_V] = 1'b0;
                flags_d[albe_pkg::FLAG_N] = r8[7];
                flags_d[albe_pkg::FLAG_Z] = (r8 == albe_pkg::BYTE_ZERO);
                wr8_d = 1'b1;
                wdata_d = {albe_pkg::BYTE_ZERO, r8};
            end
            albe_pkg::OP_WORD_SUM, albe_pkg::OP_WORD_MINUS: begin
                if (req.op == albe_pkg::OP_WORD_SUM) begin
                    r16 = req.pair + {8'h00, req.imm};
                    flags_d[albe_pkg::FLAG_V] = ~req.pair[15] & r16[15];
                    flags_d[albe_pkg::FLAG_C] = ~r16[15] & req.pair[15];
                end else begin
                    r16 = req.pair - {8'h00, req.imm};
                    flags_d[albe_pkg::FLAG_V] = req.pair[15] & ~r16[15];
                    flags_d[albe_pkg::FLAG_C] = r16[15] & ~req.pair[15];
                end
                flags_d[albe_pkg::FLAG_N] = r16[15];
                flags_d[albe_pkg::FLAG_S] =
                    r16[15] ^ flags_d[albe_pkg::FLAG_V];
                flags_d[albe_pkg::FLAG_Z] = (r16 == albe_pkg::WORD_ZERO);
                wr16_d = 1'b1;
                wdata_d = r16;
                cyc_d = albe_pkg::CYC_TWO;
            end
            albe_pkg::OP_PTR_JUMP: begin
                pc_d = req.z_ptr[PC_W-1:0];
                cyc_d = albe_pkg::CYC_TWO;
            end
            albe_pkg::OP_PTR_CALL: begin
                pc_d = req.z_ptr[PC_W-1:0];
                push_d = 1'b1;
                cyc_d = albe_pkg::CYC_THREE;
            end
            albe_pkg::OP_EQ_SKIP, albe_pkg::OP_REG_BIT_SKIP,
            albe_pkg::OP_PORT_BIT_SKIP: begin
                if (req.op == albe_pkg::OP_EQ_SKIP) begin
                    cond = (req.dst == req.src);
                end else if (req.op == albe_pkg::OP_REG_BIT_SKIP) begin
                    cond = (req.src[req.bit_sel] == req.polarity);
                end else begin
                    cond = (req.io_bit == req.polarity);
                end
                if (cond) begin
                    pc_d = pc_q + (req.skip_two_word ?
                        PC_W'(albe_pkg::STEP_SKIP_TWO) :
                        PC_W'(albe_pkg::STEP_SKIP_ONE));
                    cyc_d = req.skip_two_word ? albe_pkg::CYC_THREE :
                        albe_pkg::CYC_TWO;
                end
            end
            albe_pkg::OP_FLAG_BRANCH, albe_pkg::OP_SIGNED_BRANCH: begin
                if (req.op == albe_pkg::OP_FLAG_BRANCH) begin
                    cond = (flags_q[req.bit_sel] == req.polarity);
                end else begin
                    cond = ((flags_q[albe_pkg::FLAG_N] ^
                        flags_q[albe_pkg::FLAG_V]) == req.polarity);
                end
                if (cond) begin
                    pc_d = pc_rel;
                    cyc_d = albe_pkg::CYC_TWO;
                end
            end
            default: begin
                pc_d = pc_next;
            end
        endcase
    end

    function automatic logic cin_op(input albe_pkg::albe_op_e op);
        cin_op = (op == albe_pkg::OP_SBC) | (op == albe_pkg::OP_CPC);
    endfunction

    // occupancy sequencer
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ready_q <= 1'b1;
            done_q <= 1'b0;
            cnt_q <= 2'h0;
        end else if (accept) begin
            cnt_q <= cyc_d - albe_pkg::CYC_ONE;
            ready_q <= (cyc_d == albe_pkg::CYC_ONE);
            done_q <= (cyc_d == albe_pkg::CYC_ONE);
        end else if (cnt_q != 2'h0) begin
            cnt_q <= cnt_q - 2'h1;
            ready_q <= (cnt_q == 2'h1);
            done_q <= (cnt_q == 2'h1);
        end else begin
            done_q <= 1'b0;
        end
    end

    // architectural state
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            flags_q <= albe_pkg::FLAGS_RST;
            pc_q <= '0;
        end else if (accept) begin
            flags_q <= flags_d;
            pc_q <= pc_d;
        end
    end

    // write-back and stack strobes
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wr8_q <= 1'b0;
            wr16_q <= 1'b0;
            wdata_q <= albe_pkg::WORD_ZERO;
            push_q <= 1'b0;
            push_addr_q <= '0;
        end else begin
            wr8_q <= accept & wr8_d;
            wr16_q <= accept & wr16_d;
            push_q <= accept & push_d;
            if (accept) begin
                wdata_q <= wdata_d;
                push_addr_q <= pc_q + PC_W'(albe_pkg::STEP_NEXT);
            end
        end
    end

    assign ready = ready_q;
    assign done = done_q;
    assign wr8_en = wr8_q;
    assign wr16_en = wr16_q;
    assign wr_data = wdata_q;
    assign flag_register = flags_q;
    assign program_counter = pc_q;
    assign push_en = push_q;
    assign push_addr = push_addr_q;

    // helper copies of the last accepted request
    logic prev_acc_q;
    albe_pkg::albe_req_s prev_q;
    logic [7:0] prev_flags_q;
    logic [PC_W-1:0] prev_pc_q;
    logic [7:0] prev_b;
    logic prev_c;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            prev_acc_q <= 1'b0;
            prev_q <= '0;
            prev_flags_q <= albe_pkg::FLAGS_RST;
            prev_pc_q <= '0;
        end else begin
            prev_acc_q <= accept;
            if (accept) begin
                prev_q <= req;
                prev_flags_q <= flags_q;
                prev_pc_q <= pc_q;
            end
        end
    end

    assign prev_b = prev_q.use_imm ? prev_q.imm : prev_q.src;
    assign prev_c = prev_flags_q[albe_pkg::FLAG_C];

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    a_carry_sum: assert property (prev_acc_q && prev_q.op == albe_pkg::OP_ADC
        |-> wr8_en && wr_data[7:0] == 8'(prev_q.dst + prev_b + prev_c))
        else $error("sum with carry result wrong");
    a_word_sum_time: assert property (accept && req.op ==
        albe_pkg::OP_WORD_SUM |=> !ready ##1 (ready && done))
        else $error("word sum not two cycles");
    a_minus_value: assert property (prev_acc_q &&
        prev_q.op == albe_pkg::OP_SUB
        |-> wr8_en && wr_data[7:0] == 8'(prev_q.dst - prev_b))
        else $error("difference wrong");
    a_minus_carry: assert property (prev_acc_q &&
        prev_q.op == albe_pkg::OP_SBC
        |-> wr_data[7:0] == 8'(prev_q.dst - prev_b - prev_c))
        else $error("carry not subtracted");
    a_word_minus: assert property (prev_acc_q &&
        prev_q.op == albe_pkg::OP_WORD_MINUS
        |-> wr16_en && wr_data == 16'(prev_q.pair - prev_q.imm))
        else $error("word minus wrong");
    a_logic_flags: assert property (prev_acc_q && (prev_q.op ==
        albe_pkg::OP_AND || prev_q.op == albe_pkg::OP_EOR)
        |-> !flag_register[albe_pkg::FLAG_V] && flag_register[albe_pkg::FLAG_Z]
        == (wr_data[7:0] == 8'h00))
        else $error("logic flags wrong");
    a_clear_mask: assert property (prev_acc_q &&
        prev_q.op == albe_pkg::OP_CLR_MASK
        |-> wr_data[7:0] == (prev_q.dst & ~prev_q.imm))
        else $error("clear mask wrong");
    a_probe_keep: assert property (prev_acc_q &&
        prev_q.op == albe_pkg::OP_PROBE
        |-> wr_data[7:0] == prev_q.dst)
        else $error("probe changed value");
    a_call_time: assert property (accept && req.op == albe_pkg::OP_PTR_CALL
        |=> (!ready && push_en && program_counter == prev_q.z_ptr[PC_W-1:0])
        ##1 !ready ##1 ready)
        else $error("pointer call timing wrong");
    a_compare_nowr: assert property (prev_acc_q && (prev_q.op ==
        albe_pkg::OP_CP || prev_q.op == albe_pkg::OP_CPC) |-> !wr8_en)
        else $error("compare wrote register");
    a_branch_cycles: assert property (prev_acc_q && (prev_q.op ==
        albe_pkg::OP_FLAG_BRANCH || prev_q.op == albe_pkg::OP_SIGNED_BRANCH)
        && prev_q.offset != 12'sh000
        |-> ready == (program_counter == prev_pc_q + 1'b1))
        else $error("branch cycle count wrong");
    a_signed_ge: assert property (prev_acc_q &&
        prev_q.op == albe_pkg::OP_SIGNED_BRANCH && !prev_q.polarity &&
        !(prev_flags_q[albe_pkg::FLAG_N] ^ prev_flags_q[albe_pkg::FLAG_V])
        |-> program_counter == PC_W'(prev_pc_q + prev_q.offset + 1))
        else $error("signed branch target wrong");
    a_flags_hold: assert property (prev_acc_q && prev_q.op >=
        albe_pkg::OP_PTR_JUMP |-> flag_register == prev_flags_q)
        else $error("flags changed");

    c_word_sum: cover property (accept && req.op == albe_pkg::OP_WORD_SUM);
    c_two_word_skip: cover property (prev_acc_q && prev_q.skip_two_word &&
        program_counter == prev_pc_q + 2'h3);
    c_branch_taken: cover property (prev_acc_q && !ready &&
        prev_q.op == albe_pkg::OP_FLAG_BRANCH);

endmodule

// ===== testbench/albe_decoder_model.sv
// request source standing in for the decoder and register file
`timescale 1ns/100ps
module albe_decoder_model (
    input wire logic sys_clk,
    input wire logic ready,
    output logic req_valid,
    output albe_pkg::albe_req_s req
);
    initial begin
        req_valid = 1'b0;
        req = '0;
    end

    // present after gap idle cycles, hold until taken, then scramble
    task automatic send(input albe_pkg::albe_req_s r, input int gap);
        repeat (gap) @(posedge sys_clk);
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req <= r;
        do @(negedge sys_clk); while (ready !== 1'b1);
        @(posedge sys_clk);
        req_valid <= 1'b0;
        req <= ~r;
    endtask
endmodule

// ===== testbench/arith_logic_branch_execute_tb.sv
// self-checking bench for the execute block
`timescale 1ns/100ps
module arith_logic_branch_execute_tb;
    localparam int PCW = 12;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic req_valid;
    logic ready;
    logic done;
    logic wr8_en;
    logic wr16_en;
    logic push_en;
    albe_pkg::albe_req_s req;
    logic [15:0] wr_data;
    logic [7:0] flag_register;
    logic [PCW-1:0] program_counter;
    logic [PCW-1:0] push_addr;
    int error_cnt = 0;
    int tests_run = 0;
    int m_pc = 0;
    logic [7:0] m_flags = 8'h00;

    always #25 sys_clk = ~sys_clk;

    albe_core #(.PC_W(PCW)) albe_core_inst (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .req_valid(req_valid),
        .req(req),
        .ready(ready),
        .done(done),
        .wr8_en(wr8_en),
        .wr16_en(wr16_en),
        .wr_data(wr_data),
        .flag_register(flag_register),
        .program_counter(program_counter),
        .push_en(push_en),
        .push_addr(push_addr)
    );

    albe_decoder_model albe_decoder_model_inst (
        .sys_clk(sys_clk),
        .ready(ready),
        .req_valid(req_valid),
        .req(req)
    );

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what,
                     seen, exp);
        end
    endtask

    task automatic do_reset();
        @(posedge sys_clk);
        nrst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        chk({ready, done, wr8_en, wr16_en, push_en}, 16, "reset strobes");
        chk(program_counter, 0, "reset pc");
        chk(flag_register, albe_pkg::FLAGS_RST, "reset flags");
        @(posedge sys_clk);
        nrst <= 1'b1;
        m_pc = 0;
        m_flags = albe_pkg::FLAGS_RST;
    endtask

    function automatic logic [7:0] pick();
        logic [7:0] v[5] = '{8'h00, 8'h7f, 8'h80, 8'hff, 8'h0f};
        return ($urandom_range(5) == 5) ? 8'($urandom) : v[$urandom_range(4)];
    endfunction

    // reference model, then issue and compare every result
    task automatic run(input albe_pkg::albe_req_s r, input int gap);
        int d, b, c, res, n, npc, ret, w8, w16, psh;
        logic [7:0] f;
        logic cond;
        logic cy;
        d = r.dst;
        b = r.use_imm ? r.imm : r.src;
        cy = r.op == albe_pkg::OP_ADC || r.op == albe_pkg::OP_SBC ||
             r.op == albe_pkg::OP_CPC;
        c = cy ? m_flags[0] : 0;
        f = m_flags;
        n = 1;
        npc = m_pc + 1;
        ret = m_pc + 1;
        w8 = 0;
        w16 = 0;
        psh = 0;
        res = 0;
        cond = 1'b0;
        case (r.op)
            albe_pkg::OP_ADD, albe_pkg::OP_ADC: begin
                res = d + b + c;
                f[5] = ((d % 16) + (b % 16) + c) > 15;
                f[3] = (d[7] == b[7]) && (res[7] != d[7]);
                f[0] = res[8];
                w8 = 1;
            end
            albe_pkg::OP_SUB, albe_pkg::OP_SBC, albe_pkg::OP_CP,
            albe_pkg::OP_CPC: begin
                res = d - b - c;
                f[5] = ((d % 16) - (b % 16) - c) < 0;
                f[3] = (d[7] != b[7]) && (res[7] != d[7]);
                f[0] = res < 0;
                w8 = r.op == albe_pkg::OP_SUB || r.op == albe_pkg::OP_SBC;
            end
            albe_pkg::OP_AND: res = d & b;
            albe_pkg::OP_OR: res = d | b;
            albe_pkg::OP_EOR: res = d ^ b;
            albe_pkg::OP_SET_MASK: res = d | r.imm;
            albe_pkg::OP_CLR_MASK: res = d & (8'hff - r.imm);
            albe_pkg::OP_PROBE: res = d & d;
            albe_pkg::OP_WORD_SUM, albe_pkg::OP_WORD_MINUS: begin
                res = (r.op == albe_pkg::OP_WORD_SUM) ? r.pair + r.imm
                                                      : r.pair - r.imm;
                f[0] = res < 0 || res > 32'hffff;
                f[3] = (r.op == albe_pkg::OP_WORD_SUM) ? !r.pair[15] && res[15]
                                                       : r.pair[15] && !res[15];
                f[1] = res[15:0] == 16'h0000;
                f[2] = res[15];
                f[4] = f[2] ^ f[3];
                w16 = 1;
                n = 2;
            end
            albe_pkg::OP_PTR_JUMP: begin
                npc = r.z_ptr;
                n = 2;
            end
            albe_pkg::OP_PTR_CALL: begin
                npc = r.z_ptr;
                n = 3;
                psh = 1;
            end
            albe_pkg::OP_EQ_SKIP: cond = r.dst == r.src;
            albe_pkg::OP_REG_BIT_SKIP: cond = r.src[r.bit_sel] == r.polarity;
            albe_pkg::OP_PORT_BIT_SKIP: cond = r.io_bit == r.polarity;
            albe_pkg::OP_FLAG_BRANCH: cond = m_flags[r.bit_sel] == r.polarity;
            albe_pkg::OP_SIGNED_BRANCH: cond = (m_flags[2] ^ m_flags[3]) == r.polarity;
            default: ;
        endcase
        if (r.op >= albe_pkg::OP_AND && r.op <= albe_pkg::OP_PROBE) begin
            f[3] = 1'b0;
            w8 = 1;
        end
        if (r.op >= albe_pkg::OP_ADD && r.op <= albe_pkg::OP_PROBE) begin
            f[1] = (res[7:0] == 8'h00) && (!cy || r.op == albe_pkg::OP_ADC ||
                                           m_flags[1]);
            f[2] = res[7];
        end
        if (cond && r.op <= albe_pkg::OP_PORT_BIT_SKIP) begin
            n = r.skip_two_word ? 3 : 2;
            npc = m_pc + n;
        end
        if (cond && r.op >= albe_pkg::OP_FLAG_BRANCH) begin
            n = 2;
            npc = m_pc + r.offset + 1;
        end
        albe_decoder_model_inst.send(r, gap);
        @(negedge sys_clk);
        chk(program_counter, npc[PCW-1:0], "pc");
        chk(flag_register, f, "flags");
        chk({wr8_en, wr16_en, push_en}, {w8[0], w16[0], psh[0]}, "strobes");
        if (w8 == 1) chk(wr_data[7:0], res[7:0], "byte");
        if (w16 == 1) chk(wr_data, res[15:0], "word");
        if (psh == 1) chk(push_addr, ret[PCW-1:0], "return address");
        for (int k = 1; k <= n; k++) begin
            chk({ready, done}, {2{k == n}}, "cycle count");
            if (k < n) @(negedge sys_clk);
        end
        m_flags = f;
        m_pc = npc[PCW-1:0];
    endtask

    initial begin
        albe_pkg::albe_req_s r;
        logic [95:0] rnd;
        void'($urandom(32'hba2c));
        do_reset();
        for (int i = 0; i < 660; i++) begin
            rnd = {$urandom, $urandom, $urandom};
            r = rnd[79:0];
            r.op = albe_pkg::albe_op_e'(i % 22);
            r.dst = pick();
            r.src = ($urandom_range(1) == 1) ? r.dst : pick();
            r.imm = pick();
            r.pair = {pick(), pick()};
            if (r.op == albe_pkg::OP_REG_BIT_SKIP) r.dst = r.src;
            if (i == 330) do_reset();
            run(r, $urandom_range(2));
        end
        complete_run();
    end

    initial begin
        #(50 * 20000);
        error_cnt++;
        complete_run();
    end
endmodule
